// [inc/spcg_regs.vh]
// register map, field layout and codes of the sleep port clock gating block
`ifndef SPCG_REGS_VH
`define SPCG_REGS_VH

// register byte offsets
`define SPCG_RUN_GATE_OFF 12'h108
`define SPCG_SLEEP_GATE_OFF 12'h118
`define SPCG_DEEP_GATE_OFF 12'h128
`define SPCG_CLK_CONFIG_OFF 12'h200
`define SPCG_IRQ_STATUS_OFF 12'h210
`define SPCG_IRQ_ENABLE_OFF 12'h214
`define SPCG_IRQ_CLEAR_OFF 12'h218

// reset values
`define SPCG_GATE_RESET 8'h00
`define SPCG_WORD_ZERO 32'h00000000

// gating field layout: port a at bit 0 up to port h at bit 7
`define SPCG_GATE_MSB 7
`define SPCG_PORT_A_BIT 0
`define SPCG_PORT_H_BIT 7

// clock config field: automatic gating select
`define SPCG_AUTO_GATING_BIT 0

// interrupt status bits
`define SPCG_IRQ_FAULT_BIT 0
`define SPCG_IRQ_MODE_BIT 1
`define SPCG_IRQ_MSB 1

// power mode codes from the power manager
`define SPCG_MODE_RUN 2'h0
`define SPCG_MODE_SLEEP 2'h1
`define SPCG_MODE_DEEP 2'h2

// bus response codes
`define SPCG_RESP_OKAY 2'h0
`define SPCG_RESP_SLVERR 2'h2

`endif

// [rtl/spcg_top.v]
// sleep port clock gating block with axi4-lite register slave
`timescale 1ns/1ns
`include "spcg_regs.vh"

module spcg_top #(
  parameter ADDR_W = 12,
  parameter NUM_PORTS = 8
) (
  // clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // axi4-lite write address
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [ADDR_W-1:0] s_axi_awaddr_in,
  input wire [2:0] s_axi_awprot_in,
  // axi4-lite write data
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output reg [1:0] s_axi_bresp_out,
  // axi4-lite read address
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  input wire [2:0] s_axi_arprot_in,
  // axi4-lite read data
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  // power manager
  input wire [1:0] pwr_mode_in,
  // port access watch
  input wire port_access_in,
  input wire [NUM_PORTS-1:0] port_select_in,
  output reg port_bus_fault_out,
  // port clock enables
  output reg [NUM_PORTS-1:0] port_clk_en_out,
  // interrupt
  output wire irq_out
);

  // register file
  reg [NUM_PORTS-1:0] run_port_clock_gate;
  reg [NUM_PORTS-1:0] sleep_port_clock_gate;
  reg [NUM_PORTS-1:0] deepsleep_port_clock_gate;
  reg auto_gating_select;
  reg [`SPCG_IRQ_MSB:0] irq_status;
  reg [`SPCG_IRQ_MSB:0] irq_enable;

  // write channel holding
  reg aw_full;
  reg [ADDR_W-1:0] aw_addr;
  reg w_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // event tracking
  reg [1:0] prev_mode;
  reg [NUM_PORTS-1:0] next_clk_en;
  reg [31:0] next_rdata;
  reg next_rd_ok;
  wire do_write;
  wire wr_ok;
  wire fault_event;
  wire mode_event;
  wire [`SPCG_IRQ_MSB:0] irq_events;
  wire [`SPCG_IRQ_MSB:0] irq_clear;

  // address compare on word index
  function addr_is;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] off;
    begin
      addr_is = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    end
  endfunction

  // mapped address check
  function addr_mapped;
    input [ADDR_W-1:0] addr;
    begin
      addr_mapped = addr_is(addr, `SPCG_RUN_GATE_OFF) ||
        addr_is(addr, `SPCG_SLEEP_GATE_OFF) ||
        addr_is(addr, `SPCG_DEEP_GATE_OFF) ||
        addr_is(addr, `SPCG_CLK_CONFIG_OFF) ||
        addr_is(addr, `SPCG_IRQ_STATUS_OFF) ||
        addr_is(addr, `SPCG_IRQ_ENABLE_OFF) ||
        addr_is(addr, `SPCG_IRQ_CLEAR_OFF);
    end
  endfunction

  // low byte merge under strobe
  function [NUM_PORTS-1:0] merge_low;
    input [NUM_PORTS-1:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge_low = strb[0] ? data[NUM_PORTS-1:0] : old;
    end
  endfunction

  // zero-extend a field into a bus word
  function [31:0] widen;
    input [NUM_PORTS-1:0] val;
    begin
      widen = `SPCG_WORD_ZERO;
      widen[NUM_PORTS-1:0] = val;
    end
  endfunction

  // handshakes: one write and one read at a time
  assign s_axi_awready_out = !aw_full && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_full && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  // execute only with both halves held and the last response gone
  assign do_write = aw_full && w_full && !s_axi_bvalid_out;
  // unmapped places answer with a slave error and change nothing
  assign wr_ok = addr_mapped(aw_addr);

  // write address capture
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      aw_full <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  // write data capture
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      w_full <= 1'b0;
      w_data <= `SPCG_WORD_ZERO;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  // write response after both halves
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SPCG_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_ok ? `SPCG_RESP_OKAY : `SPCG_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // gating and config registers
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      run_port_clock_gate <= `SPCG_GATE_RESET;
      sleep_port_clock_gate <= `SPCG_GATE_RESET;
      deepsleep_port_clock_gate <= `SPCG_GATE_RESET;
      auto_gating_select <= 1'b0;
      irq_enable <= {(`SPCG_IRQ_MSB+1){1'b0}};
    end else if (do_write) begin
      if (addr_is(aw_addr, `SPCG_RUN_GATE_OFF))
        run_port_clock_gate <= merge_low(run_port_clock_gate, w_data, w_strb);
      if (addr_is(aw_addr, `SPCG_SLEEP_GATE_OFF))
        sleep_port_clock_gate <= merge_low(sleep_port_clock_gate, w_data, w_strb);
      if (addr_is(aw_addr, `SPCG_DEEP_GATE_OFF))
        deepsleep_port_clock_gate <= merge_low(deepsleep_port_clock_gate, w_data, w_strb);
      if (addr_is(aw_addr, `SPCG_CLK_CONFIG_OFF) && w_strb[0])
        auto_gating_select <= w_data[`SPCG_AUTO_GATING_BIT];
      if (addr_is(aw_addr, `SPCG_IRQ_ENABLE_OFF) && w_strb[0])
        irq_enable <= w_data[`SPCG_IRQ_MSB:0];
    end
  end

  // read data mux
  always @* begin
    next_rdata = `SPCG_WORD_ZERO;
    next_rd_ok = addr_mapped(s_axi_araddr_in);
    if (addr_is(s_axi_araddr_in, `SPCG_RUN_GATE_OFF))
      next_rdata = widen(run_port_clock_gate);
    else if (addr_is(s_axi_araddr_in, `SPCG_SLEEP_GATE_OFF))
      next_rdata = widen(sleep_port_clock_gate);
    else if (addr_is(s_axi_araddr_in, `SPCG_DEEP_GATE_OFF))
      next_rdata = widen(deepsleep_port_clock_gate);
    else if (addr_is(s_axi_araddr_in, `SPCG_CLK_CONFIG_OFF))
      next_rdata[`SPCG_AUTO_GATING_BIT] = auto_gating_select;
    else if (addr_is(s_axi_araddr_in, `SPCG_IRQ_STATUS_OFF))
      next_rdata[`SPCG_IRQ_MSB:0] = irq_status;
    else if (addr_is(s_axi_araddr_in, `SPCG_IRQ_ENABLE_OFF))
      next_rdata[`SPCG_IRQ_MSB:0] = irq_enable;
  end

  // read response one cycle after address
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= `SPCG_WORD_ZERO;
      s_axi_rresp_out <= `SPCG_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rd_ok ? `SPCG_RESP_OKAY : `SPCG_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // enable selection by power mode
  always @* begin
    // run gating is the fallback whenever auto select is off
    next_clk_en = run_port_clock_gate;
    case (pwr_mode_in)
      `SPCG_MODE_RUN: begin
        next_clk_en = run_port_clock_gate;
      end
      `SPCG_MODE_SLEEP: begin
        // sleep set only with auto gating
        if (auto_gating_select)
          next_clk_en = sleep_port_clock_gate;
      end
      `SPCG_MODE_DEEP: begin
        if (auto_gating_select)
          next_clk_en = deepsleep_port_clock_gate;
      end
      default: begin
        next_clk_en = run_port_clock_gate;
      end
    endcase
  end

  // registered port clock enables
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      port_clk_en_out <= `SPCG_GATE_RESET;
      prev_mode <= `SPCG_MODE_RUN;
    end else begin
      port_clk_en_out <= next_clk_en;
      prev_mode <= pwr_mode_in;
    end
  end

  // judged on the enables the ports see now, not the pending ones
  // fault on gated port
  assign fault_event = port_access_in && |(port_select_in & ~port_clk_en_out);
  assign mode_event = (prev_mode != pwr_mode_in);

  // bus fault pulse back to the fabric
  always @(posedge core_clk_in) begin
    if (sys_rst_in)
      port_bus_fault_out <= 1'b0;
    else
      port_bus_fault_out <= fault_event;
  end

  // sticky status, set wins over clear
  assign irq_events = {mode_event, fault_event};
  assign irq_clear = (do_write && addr_is(aw_addr, `SPCG_IRQ_CLEAR_OFF) && w_strb[0]) ?
    w_data[`SPCG_IRQ_MSB:0] : {(`SPCG_IRQ_MSB+1){1'b0}};

  // status update: clear first, so a new event is never lost
  always @(posedge core_clk_in) begin
    if (sys_rst_in)
      irq_status <= {(`SPCG_IRQ_MSB+1){1'b0}};
    else
      irq_status <= (irq_status & ~irq_clear) | irq_events;
  end

  // level interrupt from enabled status
  assign irq_out = |(irq_status & irq_enable);

endmodule // spcg_top

// [verif/spcg_chk.sv]
// assertion checker for the sleep port clock gating block
`timescale 1ns/1ns
module spcg_chk #(
  parameter NUM_PORTS = 8
) (
  // clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // register bus
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [31:0] s_axi_rdata_out,
  // gating
  input wire [1:0] pwr_mode_in,
  input wire port_access_in,
  input wire [NUM_PORTS-1:0] port_select_in,
  input wire port_bus_fault_out,
  input wire [NUM_PORTS-1:0] port_clk_en_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // gated access and write handshakes
  wire miss = port_access_in && |(port_select_in & ~port_clk_en_out);
  wire both_hs = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  wire no_wr = !(s_axi_awvalid_in && s_axi_awready_out) && !(s_axi_wvalid_in && s_axi_wready_out);
  // fault and enable relations
  a_fault_pulse: assert property (miss |=> port_bus_fault_out)
    else $error("no fault after gated access");
  a_fault_none: assert property (!miss |=> !port_bus_fault_out)
    else $error("fault without gated access");
  a_gate_reset: assert property ($fell(sys_rst_in) |-> port_clk_en_out == '0)
    else $error("enables not cleared by reset");
  a_gate_steady: assert property ((no_wr && $stable(pwr_mode_in)) [*3]
    |=> $stable(port_clk_en_out)) else $error("enables moved without cause");
  // register bus relations
  a_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_bvalid_time: assert property (both_hs |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
endmodule // spcg_chk

bind spcg_top spcg_chk #(.NUM_PORTS(NUM_PORTS)) spcg_chk_inst (
  .core_clk_in, .sys_rst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .pwr_mode_in, .port_access_in,
  .port_select_in, .port_bus_fault_out, .port_clk_en_out
);

// [verif/sleep_port_clock_gating_tb.sv]
// self-checking bench for the sleep port clock gating block
`timescale 1ns/1ns
`include "spcg_regs.vh"
module sleep_port_clock_gating_tb;
  reg clk, rst, awv, wv, bre, arv, rre, acc, pa, pw;
  reg [11:0] awa, ara;
  reg [31:0] wd;
  reg [1:0] pm;
  reg [7:0] sel;
  wire awr, wrd, bv, arr, rv, flt, irq;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  wire [7:0] en;
  integer err_count, num_checks, cyc, i;
  // device under test
  spcg_top spcg_top_inst (
    .core_clk_in(clk), .sys_rst_in(rst), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
    .s_axi_rdata_out(rdt), .s_axi_rresp_out(rr), .pwr_mode_in(pm), .port_access_in(acc),
    .port_select_in(sel), .port_bus_fault_out(flt), .port_clk_en_out(en), .irq_out(irq));
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  // verdict and end of run
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // compare one value
  task cmp(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // bus write, response checked
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    begin
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      pa = 1'b1;
      pw = 1'b1;
      while (pa | pw) begin
        @(posedge clk);
        pa = pa & ~awr;
        pw = pw & ~wrd;
        awv <= pa;
        wv <= pw;
      end
      while (bv !== 1'b1) @(posedge clk);
      // ready only after the response is seen, so the slave must hold it
      bre <= 1'b1;
      @(posedge clk);
      cmp({30'h0, br}, {30'h0, er});
      bre <= 1'b0;
      @(posedge clk);
    end
  endtask
  // bus read, data and response checked
  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    begin
      arv <= 1'b1;
      ara <= a;
      @(posedge clk);
      while (arr !== 1'b1) @(posedge clk);
      arv <= 1'b0;
      @(posedge clk);
      while (rv !== 1'b1) @(posedge clk);
      // late ready, so the slave must hold its read data
      rre <= 1'b1;
      @(posedge clk);
      cmp(rdt, e);
      cmp({30'h0, rr}, {30'h0, er});
      rre <= 1'b0;
      @(posedge clk);
    end
  endtask
  // set power mode, check enables
  task mode_chk(input [1:0] m, input [7:0] e);
    begin
      pm <= m;
      repeat (3) @(posedge clk);
      cmp({24'h000000, en}, {24'h000000, e});
    end
  endtask
  // one port access, check fault pulse
  task acc_chk(input [7:0] s, input e);
    begin
      acc <= 1'b1;
      sel <= s;
      @(posedge clk);
      acc <= 1'b0;
      @(posedge clk);
      cmp({31'h0, flt}, {31'h0, e});
    end
  endtask
  // reset values
  task t_reset;
    begin
      rd(`SPCG_SLEEP_GATE_OFF, 32'h0, `SPCG_RESP_OKAY);
      rd(`SPCG_RUN_GATE_OFF, 32'h0, `SPCG_RESP_OKAY);
      cmp({24'h000000, en}, 32'h0);
      $display("reset test done");
    end
  endtask
  // sleep gating write and read back, unmapped place
  task t_regs;
    begin
      wr(`SPCG_SLEEP_GATE_OFF, 32'h0000005A, `SPCG_RESP_OKAY);
      rd(`SPCG_SLEEP_GATE_OFF, 32'h5A, `SPCG_RESP_OKAY);
      wr(12'h0F0, 32'hFF, `SPCG_RESP_SLVERR);
      rd(12'h0F0, 32'h0, `SPCG_RESP_SLVERR);
      $display("register test done");
    end
  endtask
  // register choice per mode and auto select
  task t_select;
    begin
      wr(`SPCG_RUN_GATE_OFF, 32'h0F, `SPCG_RESP_OKAY);
      wr(`SPCG_SLEEP_GATE_OFF, 32'hA5, `SPCG_RESP_OKAY);
      wr(`SPCG_DEEP_GATE_OFF, 32'h3C, `SPCG_RESP_OKAY);
      mode_chk(`SPCG_MODE_SLEEP, 8'h0F);
      mode_chk(`SPCG_MODE_DEEP, 8'h0F);
      wr(`SPCG_CLK_CONFIG_OFF, 32'h1, `SPCG_RESP_OKAY);
      mode_chk(`SPCG_MODE_SLEEP, 8'hA5);
      mode_chk(`SPCG_MODE_DEEP, 8'h3C);
      mode_chk(2'h3, 8'h0F);
      mode_chk(`SPCG_MODE_RUN, 8'h0F);
      $display("select test done");
    end
  endtask
  // every port, enabled and gated
  task t_fault;
    begin
      wr(`SPCG_RUN_GATE_OFF, 32'h0F, `SPCG_RESP_OKAY);
      for (i = 0; i < 8; i = i + 1) begin
        acc_chk(8'h01 << i, i > 3);
      end
      $display("fault test done");
    end
  endtask
  // interrupt raise, mask, clear
  task t_irq;
    begin
      rd(`SPCG_IRQ_STATUS_OFF, 32'h3, `SPCG_RESP_OKAY);
      cmp({31'h0, irq}, 32'h0);
      wr(`SPCG_IRQ_ENABLE_OFF, 32'h1, `SPCG_RESP_OKAY);
      cmp({31'h0, irq}, 32'h1);
      wr(`SPCG_IRQ_CLEAR_OFF, 32'h3, `SPCG_RESP_OKAY);
      cmp({31'h0, irq}, 32'h0);
      wr(`SPCG_IRQ_ENABLE_OFF, 32'h2, `SPCG_RESP_OKAY);
      mode_chk(`SPCG_MODE_SLEEP, 8'hA5);
      acc_chk(8'h40, 1'b1);
      cmp({31'h0, irq}, 32'h1);
      wr(`SPCG_IRQ_CLEAR_OFF, 32'h2, `SPCG_RESP_OKAY);
      cmp({31'h0, irq}, 32'h0);
      $display("interrupt test done");
    end
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    {awv, wv, bre, arv, rre, acc} = 6'h00;
    {awa, ara, wd, pm, sel} = 66'h0;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_select;
    t_fault;
    t_irq;
    wrap_up;
  end
endmodule // sleep_port_clock_gating_tb
